// >>> inc/sac_pkg.sv
// Constants shared by the successive-approximation conversion control
//Behaviour
//- Done line goes high within 1.5 us of start pulse rising edge.
//- Conversion begins on the falling edge of the start pulse.
//- Trial bits step one at a time from most to least significant.
//- Keep a trial bit unless the DAC sum exceeds the input; then clear it.
//- Start to done takes 10 to 30 us, typically 20 us.
//- After the last bit the done line goes low; result is complete.
//- While output enable is low, all result bits drive the data outputs.
//- While output enable is high, data outputs stay in high impedance.
//- Unipolar result is straight binary; bipolar result is offset binary.
//- Bipolar mode switches in an offset of MSB weight less half LSB.
//- Range input tied to common selects unipolar 0 to +10 V.
//- Range input left open selects bipolar -5 to +5 V.
package sac_pkg;

	localparam int CLK_PERIOD_NS = 50;
	localparam int RESULT_BITS = 8;
	localparam int SYNC_STAGES = 3;

	// Least start pulse width, rounded up to whole cycles
	localparam int START_PULSE_MIN_NS = 500;
	localparam int START_PULSE_MIN_CYC =
		(START_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Longest delay from start rising edge to done high, rounded down
	localparam int RESET_ACK_MAX_NS = 1500;
	localparam int RESET_ACK_MAX_CYC = RESET_ACK_MAX_NS / CLK_PERIOD_NS;

	// Conversion time window
	localparam int CONV_MIN_NS = 10000;
	localparam int CONV_TYP_NS = 20000;
	localparam int CONV_MAX_NS = 30000;
	localparam int CONV_MIN_CYC =
		(CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_TYP_CYC = CONV_TYP_NS / CLK_PERIOD_NS;
	localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;

	// Cycles spent on each trial bit at the typical rate
	localparam int BIT_CYC_TYP = CONV_TYP_CYC / RESULT_BITS;

	// Values after reset
	localparam logic [RESULT_BITS-1:0] RESULT_RESET = 8'h00;
	localparam logic DONE_N_RESET = 1'b1;

endpackage : sac_pkg

// >>> hw/sac_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module sac_pin_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin and synchronised level
	input wire logic pin,
	output logic level
);

	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= RESET_VALUE;
			stage2 <= RESET_VALUE;
			stage3 <= RESET_VALUE;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A change counts only once the later two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= RESET_VALUE;
		end else if (stage2 == stage3) begin
			level <= stage3;
		end
	end

endmodule : sac_pin_sync

// >>> hw/sac_bit_timer.sv
// Divider producing one enable pulse per trial-bit period
`timescale 1ns/10ps
module sac_bit_timer #(
	parameter int COUNT = sac_pkg::BIT_CYC_TYP
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic restart,
	input wire logic run,
	// Enable pulse
	output logic tick
);

	localparam int W = (COUNT > 1) ? $clog2(COUNT) : 1;
	localparam logic [W-1:0] LAST = W'(COUNT - 1);

	if (COUNT < 2) begin : g_bad_count
		$error("sac_bit_timer: COUNT must be at least 2");
	end

	logic [W-1:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (restart || !run || count == LAST) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 1'b0;
		end else begin
			tick <= run && !restart && (count == LAST);
		end
	end

endmodule : sac_bit_timer

// >>> hw/sac_conversion_control.sv
// Successive-approximation conversion control and result outputs
`timescale 1ns/10ps
module sac_conversion_control #(
	parameter int RESULT_BITS = sac_pkg::RESULT_BITS,
	parameter int BIT_CYCLES = sac_pkg::BIT_CYC_TYP
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host control pins
	input wire logic convert,
	input wire logic data_enable_n,
	// Range select pin, high when left open
	input wire logic range_open,
	// Analog front end
	input wire logic dac_sum_exceeds,
	output logic [RESULT_BITS-1:0] dac_code,
	output logic bipolar_offset_on,
	// Completion and data pins
	output logic conversion_done_n,
	output logic [RESULT_BITS-1:0] data_out,
	output logic data_oe,
	// Status
	output logic conversion_busy,
	output logic start_pulse_short
);

	typedef enum logic [1:0] {
		SAC_IDLE,
		SAC_CLEARED,
		SAC_TRIAL
	} sac_state_e;

	// Worst-case start-to-done span: sync and edge detect, trials, done flop
	localparam int LATENCY_CYC = sac_pkg::SYNC_STAGES + 2;
	localparam int CONV_CYC = BIT_CYCLES * RESULT_BITS + LATENCY_CYC;
	localparam int PULSE_W = $clog2(sac_pkg::START_PULSE_MIN_CYC + 1);
	localparam logic [PULSE_W-1:0] PULSE_MIN =
		PULSE_W'(sac_pkg::START_PULSE_MIN_CYC);
	// Top trial bit, loaded on the start fall
	localparam logic [RESULT_BITS-1:0] TOP_BIT =
		{1'b1, {(RESULT_BITS-1){1'b0}}};

	if (RESULT_BITS != sac_pkg::RESULT_BITS) begin : g_bad_bits
		$error("sac_conversion_control: result width must be 8");
	end
	if (CONV_CYC < sac_pkg::CONV_MIN_CYC ||
			CONV_CYC > sac_pkg::CONV_MAX_CYC) begin : g_bad_time
		$error("sac_conversion_control: BIT_CYCLES out of time window");
	end
	if (BIT_CYCLES <= sac_pkg::SYNC_STAGES + 1) begin : g_bad_settle
		$error("sac_conversion_control: BIT_CYCLES too short to settle");
	end
	if (LATENCY_CYC > sac_pkg::RESET_ACK_MAX_CYC) begin : g_bad_ack
		$error("sac_conversion_control: start acknowledge too slow");
	end

	// Reset release through two flip-flops
	logic rst_meta_n;
	logic rst_sync_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// Synchronised pin levels; the comparator is treated as a pin since
	// its output settles asynchronously to the clock
	logic convert_s;
	logic enable_n_s;
	logic range_open_s;
	logic exceeds_s;

	sac_pin_sync #(
		.RESET_VALUE(1'b0)
	) u_sync_convert (
		.clk(clk),
		.rst_n(rst_sync_n),
		.pin(convert),
		.level(convert_s)
	);

	sac_pin_sync #(
		.RESET_VALUE(1'b1)
	) u_sync_enable (
		.clk(clk),
		.rst_n(rst_sync_n),
		.pin(data_enable_n),
		.level(enable_n_s)
	);

	sac_pin_sync #(
		.RESET_VALUE(1'b0)
	) u_sync_range (
		.clk(clk),
		.rst_n(rst_sync_n),
		.pin(range_open),
		.level(range_open_s)
	);

	sac_pin_sync #(
		.RESET_VALUE(1'b0)
	) u_sync_compare (
		.clk(clk),
		.rst_n(rst_sync_n),
		.pin(dac_sum_exceeds),
		.level(exceeds_s)
	);

	// Start pulse edges
	logic convert_prev;
	logic start_rise;
	logic start_fall;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			convert_prev <= 1'b0;
		end else begin
			convert_prev <= convert_s;
		end
	end

	assign start_rise = convert_s && !convert_prev;
	assign start_fall = !convert_s && convert_prev;

	// Sequencer state
	sac_state_e state;
	logic bit_tick;
	logic [RESULT_BITS-1:0] approximation_register;
	logic [RESULT_BITS-1:0] trial_mask;
	logic [RESULT_BITS-1:0] next_approximation;
	logic last_trial;

	assign last_trial = trial_mask[0];

	// Decodes shared by the register, the timer and the done line
	logic trial_active;
	logic load_top;
	logic conv_finish;

	assign trial_active = (state == SAC_TRIAL);
	assign load_top = (state == SAC_CLEARED) && start_fall;
	assign conv_finish = trial_active && bit_tick && last_trial;

	// Restarted on the start fall so the top bit gets a full period
	sac_bit_timer #(
		.COUNT(BIT_CYCLES)
	) u_bit_timer (
		.clk(clk),
		.rst_n(rst_sync_n),
		.restart(start_fall),
		.run(trial_active),
		.tick(bit_tick)
	);

	// A new rising edge always aborts and clears, even mid-conversion,
	// and a fall without a rise before it is ignored
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= SAC_IDLE;
		end else if (start_rise) begin
			state <= SAC_CLEARED;
		end else begin
			unique case (state)
				SAC_IDLE: begin
					state <= SAC_IDLE;
				end
				SAC_CLEARED: begin
					if (start_fall) begin
						state <= SAC_TRIAL;
					end
				end
				SAC_TRIAL: begin
					if (bit_tick && last_trial) begin
						state <= SAC_IDLE;
					end
				end
				// Spare state code falls back to idle
				default: begin
					state <= SAC_IDLE;
				end
			endcase
		end
	end

	// Decide the bit on trial, then raise the next lower one
	always_comb begin
		next_approximation = approximation_register;
		if (exceeds_s) begin
			next_approximation = approximation_register & ~trial_mask;
		end
		next_approximation = next_approximation | (trial_mask >> 1);
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			approximation_register <= sac_pkg::RESULT_RESET;
		end else if (start_rise) begin
			approximation_register <= sac_pkg::RESULT_RESET;
		end else if (load_top) begin
			approximation_register <= TOP_BIT;
		end else if (trial_active && bit_tick) begin
			approximation_register <= next_approximation;
		end
	end

	// Trial mask walks down one position per bit period and ends empty
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			trial_mask <= '0;
		end else if (start_rise) begin
			trial_mask <= '0;
		end else if (load_top) begin
			trial_mask <= TOP_BIT;
		end else if (trial_active && bit_tick) begin
			trial_mask <= trial_mask >> 1;
		end
	end

	// The DAC follows the register directly
	assign dac_code = approximation_register;

	// Done line: high on start, low after the last decision
	// A rise during a conversion raises it again before the fall
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			conversion_done_n <= sac_pkg::DONE_N_RESET;
		end else if (start_rise) begin
			conversion_done_n <= 1'b1;
		end else if (conv_finish) begin
			conversion_done_n <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			conversion_busy <= 1'b0;
		end else if (start_rise) begin
			conversion_busy <= 1'b1;
		end else if (conv_finish) begin
			conversion_busy <= 1'b0;
		end
	end

	// Range mode is frozen while bits are on trial so the offset
	// current cannot change under a comparator decision
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			bipolar_offset_on <= 1'b0;
		end else if (!trial_active) begin
			bipolar_offset_on <= range_open_s;
		end
	end

	// Start pulse width measured in the synchronised domain; the count
	// saturates at the minimum so a long pulse cannot wrap it
	logic [PULSE_W-1:0] pulse_count;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pulse_count <= '0;
		end else if (start_rise) begin
			pulse_count <= PULSE_W'(1);
		end else if (convert_s && pulse_count != PULSE_MIN) begin
			pulse_count <= pulse_count + 1'b1;
		end
	end

	// Flags a pulse narrower than the host minimum; held until next start
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			start_pulse_short <= 1'b0;
		end else if (start_rise) begin
			start_pulse_short <= 1'b0;
		end else if (load_top) begin
			start_pulse_short <= (pulse_count < PULSE_MIN);
		end
	end

	// Output buffers: code is the register as is, offset binary in
	// bipolar mode because the offset is added on the analog side
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			data_out <= sac_pkg::RESULT_RESET;
		end else begin
			data_out <= approximation_register;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			data_oe <= 1'b0;
		end else begin
			// Pads sit outside this block and follow this enable
			data_oe <= !enable_n_s;
		end
	end

endmodule : sac_conversion_control

// >>> verification/sac_conversion_control_sva.sv
// Checker for the conversion control ports
`timescale 1ns/10ps
module sac_conversion_control_sva #(
	parameter int RESULT_BITS = 8,
	parameter int BIT_CYCLES = 50
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Inputs
	input wire logic convert,
	input wire logic data_enable_n,
	input wire logic range_open,
	input wire logic dac_sum_exceeds,
	// Outputs
	input wire logic [RESULT_BITS-1:0] dac_code,
	input wire logic bipolar_offset_on,
	input wire logic conversion_done_n,
	input wire logic [RESULT_BITS-1:0] data_out,
	input wire logic data_oe,
	input wire logic conversion_busy,
	input wire logic start_pulse_short
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Cycles since the start pin last went low
	logic [15:0] since_fall;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			since_fall <= 16'h0000;
		end else if (convert) begin
			since_fall <= 16'h0000;
		end else if (since_fall != 16'hffff) begin
			since_fall <= since_fall + 16'h0001;
		end
	end
	done_high_a: assert property (
		$rose(convert) |-> ##[1:30] conversion_done_n)
		else $error("done not raised after start");
	hold_clear_a: assert property (
		convert[*8] |-> dac_code == 8'h00 && conversion_done_n)
		else $error("trial began before start fell");
	msb_first_a: assert property (
		$fell(convert) |-> ##[3:10] dac_code == 8'h80)
		else $error("first trial not top bit");
	one_step_a: assert property (
		$past(conversion_busy) && conversion_busy && !convert
		&& $changed(dac_code)
		|-> $countones(dac_code ^ $past(dac_code)) <= 2)
		else $error("trial step changed too many bits");
	conv_time_a: assert property (
		$fell(conversion_done_n) |-> since_fall inside {[200:600]})
		else $error("conversion time out of window");
	done_bound_a: assert property (
		$fell(convert) |-> ##[1:600] !conversion_done_n)
		else $error("done never fell");
	result_out_a: assert property (
		$fell(conversion_done_n) |=> !conversion_busy
		&& data_out == dac_code)
		else $error("result not on outputs at done");
	result_hold_a: assert property (
		!conversion_done_n ##1 !conversion_done_n |-> $stable(dac_code))
		else $error("result moved while done");
	oe_on_a: assert property (
		(!data_enable_n)[*8] |-> data_oe)
		else $error("outputs not driven");
	oe_off_a: assert property (
		data_enable_n[*8] |-> !data_oe)
		else $error("outputs not released");
	mode_a: assert property (
		(!conversion_busy && $stable(range_open))[*8]
		|-> bipolar_offset_on == range_open)
		else $error("offset switch disagrees with range pin");
	cover property ($fell(conversion_done_n));
	cover property (data_oe && !conversion_done_n);
	cover property (conversion_busy && $rose(convert));
endmodule : sac_conversion_control_sva

bind sac_conversion_control sac_conversion_control_sva #(
	.RESULT_BITS(RESULT_BITS),
	.BIT_CYCLES(BIT_CYCLES)
) chk (
	.clk(clk),
	.rst_n(rst_n),
	.convert(convert),
	.data_enable_n(data_enable_n),
	.range_open(range_open),
	.dac_sum_exceeds(dac_sum_exceeds),
	.dac_code(dac_code),
	.bipolar_offset_on(bipolar_offset_on),
	.conversion_done_n(conversion_done_n),
	.data_out(data_out),
	.data_oe(data_oe),
	.conversion_busy(conversion_busy),
	.start_pulse_short(start_pulse_short)
);

// >>> verification/sac_host_model.sv
// Host model driving the start and output enable pins
`timescale 1ns/10ps
module sac_host_model (
	// Clock
	input wire logic clk,
	// Host pins
	output logic convert,
	output logic data_enable_n
);
	initial begin
		convert = 1'b0;
		data_enable_n = 1'b1;
	end
	// Start pulse; outputs are released first, width kept at 500 ns or more
	task automatic pulse(input int cyc);
		@(negedge clk);
		data_enable_n = 1'b1;
		convert = 1'b1;
		repeat ((cyc < 10) ? 10 : cyc) @(negedge clk);
		convert = 1'b0;
	endtask : pulse
	// Narrow pulse, used only to exercise the width flag
	task automatic pulse_narrow(input int cyc);
		@(negedge clk);
		data_enable_n = 1'b1;
		convert = 1'b1;
		repeat (cyc) @(negedge clk);
		convert = 1'b0;
	endtask : pulse_narrow
	task automatic enable(input logic on);
		@(negedge clk);
		data_enable_n = !on;
	endtask : enable
endmodule : sac_host_model

// >>> verification/sac_conversion_control_tb.sv
// Self-checking bench for the conversion control
`timescale 1ns/10ps
module sac_conversion_control_tb;
	logic clk;
	logic rst_n;
	logic range_open;
	logic [7:0] vin;
	logic convert;
	logic data_enable_n;
	logic exceeds;
	logic [7:0] dac_code;
	logic [7:0] data_out;
	logic offset_on;
	logic done_n;
	logic oe;
	logic busy;
	logic short_p;
	wire [7:0] dbus;
	int num_errors;
	int n_tests;
	logic [7:0] codes [6] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'ha5, 8'h5a};
	// Ideal comparator and resolved data pins
	assign exceeds = dac_code > vin;
	assign dbus = oe ? data_out : 8'hzz;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	sac_host_model host (
		.clk(clk),
		.convert(convert),
		.data_enable_n(data_enable_n)
	);
	sac_conversion_control DUT (
		.clk(clk),
		.rst_n(rst_n),
		.convert(convert),
		.data_enable_n(data_enable_n),
		.range_open(range_open),
		.dac_sum_exceeds(exceeds),
		.dac_code(dac_code),
		.bipolar_offset_on(offset_on),
		.conversion_done_n(done_n),
		.data_out(data_out),
		.data_oe(oe),
		.conversion_busy(busy),
		.start_pulse_short(short_p)
	);
	task automatic chk(input string what, input logic [7:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	task automatic wait_done(output int cyc);
		cyc = 0;
		while (done_n !== 1'b0) begin
			@(negedge clk);
			cyc++;
			if (cyc > 1000) begin
				num_errors++;
				final_report();
			end
		end
	endtask : wait_done
	task automatic s_convert(input logic [7:0] code, input logic rng);
		int cyc;
		vin = code;
		range_open = rng;
		host.pulse(12);
		wait_done(cyc);
		chk("time", 8'h01, 8'(cyc + 12 >= 200 && cyc + 12 <= 600));
		chk("code", code, dac_code);
		chk("bus_off", 8'hzz, dbus);
		host.enable(1'b1);
		repeat (8) @(negedge clk);
		chk("bus_on", code, dbus);
		chk("offset", {7'h00, rng}, {7'h00, offset_on});
		chk("short", 8'h00, {7'h00, short_p});
	endtask : s_convert
	task automatic s_abort;
		int cyc;
		vin = 8'h3c;
		host.pulse(12);
		repeat (100) @(negedge clk);
		chk("mid_done", 8'h01, {7'h00, done_n});
		host.pulse(12);
		chk("restart", 8'h00, dac_code);
		chk("busy", 8'h01, {7'h00, busy});
		wait_done(cyc);
		repeat (20) @(negedge clk);
		chk("abort_code", 8'h3c, dac_code);
	endtask : s_abort
	task automatic s_narrow;
		int cyc;
		vin = 8'hc3;
		host.pulse_narrow(6);
		wait_done(cyc);
		chk("narrow_flag", 8'h01, {7'h00, short_p});
		chk("narrow_code", 8'hc3, dac_code);
	endtask : s_narrow
	initial begin
		rst_n = 1'b0;
		range_open = 1'b0;
		vin = 8'h00;
		num_errors = 0;
		n_tests = 0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		chk("rst_done", 8'h01, {7'h00, done_n});
		foreach (codes[i]) begin
			s_convert(codes[i], i[0]);
		end
		s_abort();
		s_narrow();
		final_report();
	end
endmodule : sac_conversion_control_tb
